// ==== design/vsp_reg_port.sv ====
/*
 * Register port of the vibration sensor: frame decode, user register
 * map, global commands, nonvolatile load and save, busy pin.
 * Assumes capture engine and nonvolatile store on core_clk; the
 * serial master supplies sclk, unrelated to core_clk.
 */
`timescale 1ns/1ps
`include "vsp_cfg.svh"
module vsp_reg_port #(
  parameter logic [15:0] PART_ID = 16'h0a5c, // Arbitrary value
  parameter logic [15:0] LOT_LO = 16'h0001, // Arbitrary value
  parameter logic [15:0] LOT_HI = 16'h0002, // Arbitrary value
  parameter logic [15:0] SERIAL = 16'h0003 // Arbitrary value
) (
  input wire logic core_clk, // Core clock, 40 MHz
  input wire logic rst, // Reset, active high, async
  input wire logic sclk, // Serial clock from master
  input wire logic cs_n, // Chip select, active low
  input wire logic din, // Serial data in
  output logic dout, // Serial data out
  output logic dout_oe_n, // Data out enable, low drives
  output logic function_pin_one, // Busy indicator level
  output logic function_pin_one_oe_n, // Pin one enable, low drives
  output logic capture_start, // One-cycle capture request
  input wire logic capture_done, // One-cycle capture finished
  input wire vsp_pkg::vsp_word_t cap_supply, // Supply result
  input wire vsp_pkg::vsp_word_t cap_temp, // Temperature result
  input wire vsp_pkg::vsp_word_t cap_x_peak, // X peak result
  input wire vsp_pkg::vsp_word_t cap_y_peak, // Y peak result
  input wire vsp_pkg::vsp_word_t cap_z_peak, // Z peak result
  input wire vsp_pkg::vsp_word_t cap_x_win, // X sample at pointer
  input wire vsp_pkg::vsp_word_t cap_y_win, // Y sample at pointer
  input wire vsp_pkg::vsp_word_t cap_z_win, // Z sample at pointer
  output logic [9:0] sample_index, // Sample index pointer
  input wire vsp_pkg::vsp_word_t error_flags, // Error flags status
  output vsp_pkg::vsp_word_t acq_ctrl, // Acquisition control
  output logic [3:0] nv_slot, // Nonvolatile slot index
  input wire vsp_pkg::vsp_word_t nv_rdata, // Slot data, one cycle late
  output vsp_pkg::vsp_word_t nv_wdata, // Slot write data
  output logic nv_we, // Slot write strobe
  output logic ready // Boot load finished
);
  import vsp_pkg::*;

  localparam int NREG = 14;
  localparam logic [3:0] LAST = 4'(NREG - 1);

  // ----------------------------------------------------------------
  // Stored control registers
  // ----------------------------------------------------------------
  localparam logic [6:0] RW_OFF [NREG] = '{
    `VSP_A_X_TRIM, `VSP_A_Y_TRIM, `VSP_A_Z_TRIM, `VSP_A_ACQ_CTRL,
    `VSP_A_ACQ_PRD, `VSP_A_X_ALM, `VSP_A_Y_ALM, `VSP_A_Z_ALM,
    `VSP_A_S_ALM, `VSP_A_ALARM_CONTROL, `VSP_A_GPIO_CFG, `VSP_A_SELFTEST,
    `VSP_A_PIN_CFG, `VSP_A_LOWPASS_AVERAGE_COUNT};
  localparam vsp_word_t RW_RST [NREG] = '{
    `VSP_RST_ZERO, `VSP_RST_ZERO, `VSP_RST_ZERO, `VSP_RST_ACQ_CTRL,
    `VSP_RST_ZERO, `VSP_RST_ZERO, `VSP_RST_ZERO, `VSP_RST_ZERO,
    `VSP_RST_ZERO, `VSP_RST_ZERO, `VSP_RST_ZERO, `VSP_RST_ZERO,
    `VSP_RST_PIN_CFG, `VSP_RST_ZERO};
  // Self-test control has no nonvolatile copy
  localparam logic [NREG-1:0] FLASHED = 14'h37ff;
  localparam int ACQ_IDX = 3;

  vsp_word_t tx_word;
  vsp_word_t rx_word;
  logic frame_tgl;
  logic tgl_s1;
  logic tgl_s2;
  logic tgl_s3;
  logic frame_go;
  logic is_write;
  vsp_addr_t addr;
  logic [6:0] reg_off;
  logic [7:0] wdata;
  logic wr_go;
  logic rd_go;
  vsp_word_t rd_word;
  vsp_word_t rw [NREG];
  vsp_word_t flash_count;
  logic captured;
  logic busy;
  vsp_state_t state;
  logic [3:0] step;
  logic ld_en;
  logic [3:0] ld_idx;
  logic ld_pend;
  logic [3:0] ld_pend_idx;
  logic cmd_save;
  logic win_read;

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  vsp_spi_link u_link (
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .tx_word(tx_word),
    .dout(dout),
    .dout_oe_n(dout_oe_n),
    .rx_word(rx_word),
    .frame_tgl(frame_tgl)
  );

  // Frame event crosses as a toggle; rx_word is stable once it lands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= frame_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign frame_go = tgl_s2 ^ tgl_s3;

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  // write layout
  assign is_write = rx_word[`VSP_RW_BIT];
  assign addr = rx_word[`VSP_ADDR_HI:`VSP_ADDR_LO];
  assign wdata = rx_word[`VSP_DATA_HI:0];
  assign reg_off = {addr[6:1], 1'b0};
  // Write frames landing during load or save are dropped, not deferred; reads are still served
  assign wr_go = frame_go && is_write && state == VSP_RUN;
  assign rd_go = frame_go && !is_write;
  assign win_read = rd_go && (reg_off == `VSP_A_X_WIN || reg_off == `VSP_A_Y_WIN
                              || reg_off == `VSP_A_Z_WIN);

  assign capture_start = wr_go && reg_off == `VSP_A_GLOBAL && addr[0]
                         && wdata[`VSP_CMD_CAPTURE];
  assign cmd_save = wr_go && reg_off == `VSP_A_GLOBAL && addr[0]
                    && wdata[`VSP_CMD_FLASH_SAVE];

  // ----------------------------------------------------------------
  // Control registers, one byte per write
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NREG; i++) begin : g_rw
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        rw[i] <= RW_RST[i];
      end else if (ld_en && ld_idx == 4'(i) && FLASHED[i]) begin
        rw[i] <= nv_rdata;
      end else if (wr_go && reg_off == RW_OFF[i]) begin
        // odd address is the upper byte
        if (addr[0]) begin
          rw[i][15:8] <= wdata;
        end else begin
          rw[i][7:0] <= wdata;
        end
      end
    end
  end

  assign acq_ctrl = rw[ACQ_IDX];

  // Pointer: capture end rewinds it ahead of a host write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sample_index <= 10'h000;
    end else if (capture_done) begin
      sample_index <= 10'h000;
    end else if (wr_go && reg_off == `VSP_A_PNTR) begin
      if (addr[0]) begin
        sample_index[9:8] <= wdata[1:0];
      end else begin
        sample_index[7:0] <= wdata;
      end
    end else if (win_read) begin
      sample_index <= sample_index + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Capture status and busy pin
  // ----------------------------------------------------------------
  // no-capture marker until the first result
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      captured <= 1'b0;
    end else if (capture_done) begin
      captured <= 1'b1;
    end
  end

  // busy high while capturing, low when done
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
    end else if (capture_start) begin
      busy <= 1'b1;
    end else if (capture_done) begin
      busy <= 1'b0;
    end
  end

  assign function_pin_one = busy;
  assign function_pin_one_oe_n = 1'b0;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = `VSP_RST_ZERO;
    for (int i = 0; i < NREG; i++) begin
      if (reg_off == RW_OFF[i]) begin
        rd_word = rw[i];
      end
    end
    // reserved reads zero; command reads zero
    case (reg_off)
      `VSP_A_FLASH_CNT: rd_word = flash_count;
      `VSP_A_SUPPLY: rd_word = captured ? cap_supply : `VSP_NO_CAPTURE;
      `VSP_A_TEMP: rd_word = captured ? cap_temp : `VSP_NO_CAPTURE;
      `VSP_A_X_PEAK: rd_word = captured ? cap_x_peak : `VSP_NO_CAPTURE;
      `VSP_A_Y_PEAK: rd_word = captured ? cap_y_peak : `VSP_NO_CAPTURE;
      `VSP_A_Z_PEAK: rd_word = captured ? cap_z_peak : `VSP_NO_CAPTURE;
      `VSP_A_X_WIN: rd_word = captured ? cap_x_win : `VSP_NO_CAPTURE;
      `VSP_A_Y_WIN: rd_word = captured ? cap_y_win : `VSP_NO_CAPTURE;
      `VSP_A_Z_WIN: rd_word = captured ? cap_z_win : `VSP_NO_CAPTURE;
      `VSP_A_PNTR: rd_word = {6'h00, sample_index};
      `VSP_A_ERR: rd_word = error_flags;
      `VSP_A_LOT_LO: rd_word = LOT_LO;
      `VSP_A_LOT_HI: rd_word = LOT_HI;
      `VSP_A_PART_ID: rd_word = PART_ID;
      `VSP_A_SERIAL: rd_word = SERIAL;
      default: ;
    endcase
  end

  // reply loaded for the following frame
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_word <= `VSP_RST_ZERO;
    end else if (rd_go) begin
      tx_word <= rd_word;
    end else if (frame_go) begin
      tx_word <= `VSP_RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile load and save sequencer
  // ----------------------------------------------------------------
  // load before normal operation; save
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= VSP_BOOT;
      step <= 4'h0;
    end else begin
      case (state)
        VSP_BOOT: begin
          step <= step + 4'h1;
          if (step == LAST) begin
            state <= VSP_RUN;
            step <= 4'h0;
          end
        end
        VSP_RUN: begin
          if (cmd_save) begin
            state <= VSP_SAVE;
          end
        end
        VSP_SAVE: begin
          step <= step + 4'h1;
          if (step == LAST) begin
            state <= VSP_RUN;
            step <= 4'h0;
          end
        end
        default: begin
          state <= VSP_BOOT;
          step <= 4'h0;
        end
      endcase
    end
  end

  // Slot address and write data registered toward the store
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_slot <= 4'h0;
      nv_wdata <= `VSP_RST_ZERO;
      nv_we <= 1'b0;
    end else begin
      nv_slot <= step;
      nv_wdata <= rw[step];
      nv_we <= state == VSP_SAVE && FLASHED[step];
    end
  end

  // Slot register plus store latency: load target trails step by two
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ld_pend <= 1'b0;
      ld_pend_idx <= 4'h0;
      ld_en <= 1'b0;
      ld_idx <= 4'h0;
    end else begin
      ld_pend <= state == VSP_BOOT;
      ld_pend_idx <= step;
      ld_en <= ld_pend;
      ld_idx <= ld_pend_idx;
    end
  end

  // Ready once the last loaded word has landed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready <= 1'b0;
    end else if (state == VSP_RUN && !ld_en) begin
      ready <= 1'b1;
    end
  end

  // Save counter bumps once per completed save
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flash_count <= `VSP_RST_ZERO;
    end else if (state == VSP_SAVE && step == LAST) begin
      flash_count <= flash_count + 16'h0001;
    end
  end

endmodule // vsp_reg_port

// ==== design/vsp_spi_link.sv ====
/*
 * Serial-clock side of the register port: shifts the 16-bit frame in
 * and out, mode 3, most significant bit first.
 * Assumes tx_word holds still while a frame runs (it changes only in
 * the stall between frames) and that cs_n and din belong to sclk.
 */
`timescale 1ns/1ps
`include "vsp_cfg.svh"
module vsp_spi_link (
  input wire logic rst, // Core reset, active high
  input wire logic sclk, // Serial clock from the master
  input wire logic cs_n, // Chip select, active low
  input wire logic din, // Serial data in
  input wire vsp_pkg::vsp_word_t tx_word, // Reply word for next frame
  output logic dout, // Serial data out
  output logic dout_oe_n, // Data out enable, low drives the pin
  output vsp_pkg::vsp_word_t rx_word, // Last complete frame
  output logic frame_tgl // Flips once per complete frame
);
  import vsp_pkg::*;

  logic sel_rst;
  logic [3:0] cnt;
  vsp_word_t shift;
  logic dbit;
  logic started;

  // Deselect clears the frame position without needing a clock edge
  assign sel_rst = rst | cs_n;

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  // rising edge capture
  always_ff @(posedge sclk or posedge sel_rst) begin
    if (sel_rst) begin
      cnt <= 4'h0;
      shift <= `VSP_RST_ZERO;
    end else begin
      cnt <= cnt + 4'h1;
      shift <= {shift[`VSP_FRAME_BITS-2:0], din};
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_word <= `VSP_RST_ZERO;
      frame_tgl <= 1'b0;
    end else if (!cs_n && cnt == `VSP_CNT_LAST) begin
      rx_word <= {shift[`VSP_FRAME_BITS-2:0], din};
      frame_tgl <= ~frame_tgl;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  // falling edge launch; full duplex
  always_ff @(negedge sclk or posedge sel_rst) begin
    if (sel_rst) begin
      dbit <= 1'b0;
      started <= 1'b0;
    end else begin
      dbit <= tx_word[~cnt];
      started <= 1'b1;
    end
  end

  // First bit must stand before the first falling edge of mode 3
  assign dout = started ? dbit : tx_word[`VSP_FRAME_BITS-1];
  assign dout_oe_n = cs_n;

endmodule // vsp_spi_link

// ==== inc/vsp_cfg.svh ====
/*
 * Constants of the vibration sensor serial register port: byte
 * addresses, reset values, command bits and frame layout.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef VSP_CFG_SVH
`define VSP_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define VSP_FRAME_BITS 16
`define VSP_CNT_LAST 4'hf
`define VSP_RW_BIT 15
`define VSP_ADDR_HI 14
`define VSP_ADDR_LO 8
`define VSP_DATA_HI 7

// ----------------------------------------------------------------
// Byte addresses (lower byte; upper byte is one above)
// ----------------------------------------------------------------
`define VSP_A_FLASH_CNT 7'h00
`define VSP_A_X_TRIM 7'h02
`define VSP_A_Y_TRIM 7'h04
`define VSP_A_Z_TRIM 7'h06
`define VSP_A_SUPPLY 7'h0a
`define VSP_A_TEMP 7'h0c
`define VSP_A_X_PEAK 7'h0e
`define VSP_A_Y_PEAK 7'h10
`define VSP_A_Z_PEAK 7'h12
`define VSP_A_X_WIN 7'h14
`define VSP_A_Y_WIN 7'h16
`define VSP_A_Z_WIN 7'h18
`define VSP_A_PNTR 7'h1a
`define VSP_A_ACQ_CTRL 7'h1c
`define VSP_A_ACQ_PRD 7'h1e
`define VSP_A_X_ALM 7'h20
`define VSP_A_Y_ALM 7'h22
`define VSP_A_Z_ALM 7'h24
`define VSP_A_S_ALM 7'h26
`define VSP_A_ALARM_CONTROL 7'h28
`define VSP_A_GPIO_CFG 7'h32
`define VSP_A_SELFTEST 7'h34
`define VSP_A_PIN_CFG 7'h36
`define VSP_A_LOWPASS_AVERAGE_COUNT 7'h38
`define VSP_A_ERR 7'h3c
`define VSP_A_GLOBAL 7'h3e
`define VSP_A_LOT_LO 7'h52
`define VSP_A_LOT_HI 7'h54
`define VSP_A_PART_ID 7'h56
`define VSP_A_SERIAL 7'h58

// ----------------------------------------------------------------
// Reset values and command bits
// ----------------------------------------------------------------
`define VSP_RST_ZERO 16'h0000
`define VSP_RST_ACQ_CTRL 16'h0020
`define VSP_RST_PIN_CFG 16'h000f
`define VSP_NO_CAPTURE 16'h8000
`define VSP_PNTR_BITS 10
`define VSP_CMD_CAPTURE 3
`define VSP_CMD_FLASH_SAVE 4

`endif

// ==== inc/vsp_pkg.sv ====
/*
 * Types of the vibration sensor serial register port.
 * Assumes vsp_cfg.svh on the include path.
 */
package vsp_pkg;
  `include "vsp_cfg.svh"

  // Control sequencer states, one-hot
  typedef enum logic [2:0] {
    VSP_BOOT = 3'b001,
    VSP_RUN = 3'b010,
    VSP_SAVE = 3'b100
  } vsp_state_t;

  typedef logic [`VSP_FRAME_BITS-1:0] vsp_word_t;
  typedef logic [`VSP_ADDR_HI-`VSP_ADDR_LO:0] vsp_addr_t;
endpackage

// ==== verif/tb_top.sv ====
/*
 * Testbench of the register port: frames through the host model,
 * a small capture engine and nonvolatile store modelled in place.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
module tb_top;
  import vsp_pkg::*;
  localparam vsp_word_t TB_PART = 16'h2b7e; // Arbitrary value
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic capture_done = 1'b0;
  vsp_word_t cap_val = 16'h0000;
  vsp_word_t cap_x_win = 16'h0000;
  vsp_word_t error_flags = 16'h5a3c;
  vsp_word_t nv_rdata = 16'h0000;
  vsp_word_t nv_mem [14];
  vsp_word_t acq_ctrl, nv_wdata, r;
  logic sclk, cs_n, din, dout, dout_oe_n, miso, pin_one, pin_oe_n, capture_start, nv_we, ready;
  logic [9:0] sample_index;
  logic [3:0] nv_slot;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int starts = 0;

  // ----------------------------------------------------------------
  // Device, host and surroundings
  // ----------------------------------------------------------------
  vsp_reg_port #(.PART_ID(TB_PART)) u_dut (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe_n(dout_oe_n), .function_pin_one(pin_one),
    .function_pin_one_oe_n(pin_oe_n), .capture_start(capture_start),
    .capture_done(capture_done), .cap_supply(cap_val), .cap_temp(cap_val + 16'h0001),
    .cap_x_peak(cap_val + 16'h0002), .cap_y_peak(cap_val + 16'h0003),
    .cap_z_peak(cap_val + 16'h0004), .cap_x_win(cap_x_win),
    .cap_y_win(cap_x_win + 16'h0001), .cap_z_win(cap_x_win + 16'h0002),
    .sample_index(sample_index), .error_flags(error_flags), .acq_ctrl(acq_ctrl),
    .nv_slot(nv_slot), .nv_rdata(nv_rdata), .nv_wdata(nv_wdata), .nv_we(nv_we),
    .ready(ready));
  vsp_host_model u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .miso(miso));
  assign miso = dout_oe_n ? 1'bz : dout;

  always #12.5 core_clk = ~core_clk;

  // Store answers one cycle late; window follows pointer
  always @(posedge core_clk) begin
    nv_rdata <= nv_mem[nv_slot];
    if (nv_we === 1'b1) nv_mem[nv_slot] <= nv_wdata;
    cap_x_win <= {6'h10, sample_index};
    if (capture_start === 1'b1) starts++;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task give_verdict;
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task chk(input vsp_word_t got, input vsp_word_t exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  task frame(input vsp_word_t tx, output vsp_word_t rx);
    u_host.xfer(tx, 16, rx);
  endtask

  // Read request with junk data byte, reply in the following frame
  task rd(input vsp_addr_t a, input vsp_word_t exp);
    frame({1'b0, a, 8'ha5}, r);
    frame(16'h0000, r);
    chk(r, exp);
  endtask

  task wr(input vsp_addr_t a, input logic [7:0] d);
    frame({1'b1, a, d}, r);
  endtask

  task boot;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge core_clk);
    chk({15'h0000, ready}, 16'h0001);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 14; i++) nv_mem[i] = (i == 11) ? 16'h0000 : 16'h1100 + 16'(i);
    boot();
    chk(acq_ctrl, 16'h1103);
    rd(7'h02, 16'h1100);
    rd(7'h56, TB_PART);
    rd(7'h3e, 16'h0000);
    rd(7'h08, 16'h0000);
    rd(7'h3c, 16'h5a3c);
    for (int k = 0; k < 8; k++) rd(7'h0a + 7'(2 * k), 16'h8000);
    $display("test reads done");
    wr(7'h1e, 8'h34);
    wr(7'h1f, 8'h12);
    rd(7'h1e, 16'h1234);
    wr(7'h20, 8'h77);
    rd(7'h20, 16'h1177);
    wr(7'h56, 8'hff);
    rd(7'h56, TB_PART);
    u_host.xfer(16'h9eff, 8, r);
    rd(7'h1e, 16'h1234);
    $display("test writes done");
    @(posedge core_clk) cap_val <= 16'h0310;
    wr(7'h3f, 8'h08);
    chk(16'(starts), 16'h0001);
    chk({15'h0000, pin_one}, 16'h0001);
    @(posedge core_clk) capture_done <= 1'b1;
    @(posedge core_clk) capture_done <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({15'h0000, pin_one}, 16'h0000);
    chk({6'h00, sample_index}, 16'h0000);
    for (int k = 0; k < 5; k++) rd(7'h0a + 7'(2 * k), 16'h0310 + 16'(k));
    rd(7'h16, 16'h4001);
    rd(7'h18, 16'h4003);
    frame(16'h1400, r);
    frame(16'h1400, r);
    chk(r, 16'h4002);
    frame(16'h0000, r);
    chk(r, 16'h4003);
    wr(7'h1a, 8'h38);
    wr(7'h1b, 8'h01);
    chk({6'h00, sample_index}, 16'h0138);
    $display("test capture done");
    wr(7'h34, 8'h5a);
    wr(7'h3f, 8'h10);
    for (int i = 0; i < 100 && nv_we !== 1'b0; i++) @(posedge core_clk);
    chk(nv_mem[4], 16'h1234);
    chk(nv_mem[11], 16'h0000);
    rd(7'h00, 16'h0001);
    @(posedge core_clk) rst <= 1'b1;
    boot();
    rd(7'h20, 16'h1177);
    rd(7'h34, 16'h0000);
    rd(7'h0a, 16'h8000);
    $display("test save and reload done");
    give_verdict();
  end
endmodule // tb_top

// ==== verif/vsp_host_model.sv ====
/*
 * Serial master model: makes mode 3 frames on its own clock.
 * Assumes miso reads the device data line while selected.
 */
`timescale 1ns/1ps
module vsp_host_model #(
  // bench bit rate set by link clock
  parameter int HALF_NS = 6 // Half period of the serial clock
) (
  output logic sclk, // Serial clock, idles high
  output logic cs_n, // Chip select, active low
  output logic din, // Data towards the device
  input wire logic miso // Data from the device
);
  // ----------------------------------------------------------------
  // Frame driver
  // ----------------------------------------------------------------
  // Idle lines; clock stands still between frames
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n = 1'b0;
    #50;
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #HALF_NS;
      sclk = 1'b1;
      rx[i] = miso;
      #HALF_NS;
    end
    // Long stall lets the frame reach the core side and the reply load
    #50;
    cs_n = 1'b1;
    din = ~din;
    #400;
  endtask
endmodule // vsp_host_model

// ==== verif/vsp_reg_port_props.sv ====
/*
 * Checker for the vibration sensor register port: busy pin, capture
 * request, boot load, save sequence and data out enable.
 * Assumes binding to vsp_reg_port; all checks run on core_clk.
 */
`timescale 1ns/1ps
module vsp_reg_port_chk (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Reset, active high
  input wire logic cs_n, // Chip select, active low
  input wire logic dout_oe_n, // Data out enable, low drives
  input wire logic function_pin_one, // Busy indicator
  input wire logic function_pin_one_oe_n, // Pin one enable
  input wire logic capture_start, // Capture request pulse
  input wire logic capture_done, // Capture finished pulse
  input wire logic [3:0] nv_slot, // Nonvolatile slot index
  input wire logic nv_we, // Slot write strobe
  input wire logic ready // Boot load finished
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_dout_follows_select: assert property (
    dout_oe_n == cs_n) else $error("data out enable differs from select");
  a_pin_always_driven: assert property (
    function_pin_one_oe_n == 1'b0) else $error("busy pin not driven");
  a_start_one_cycle: assert property (
    capture_start |=> !capture_start) else $error("capture request too long");
  a_busy_on_start: assert property (
    capture_start |=> function_pin_one) else $error("busy not raised");
  a_busy_off_done: assert property (
    capture_done && !capture_start |=> !function_pin_one) else $error("busy not cleared");
  a_busy_holds: assert property (
    function_pin_one && !capture_done |=> function_pin_one) else $error("busy dropped early");
  a_busy_idle: assert property (
    !function_pin_one && !capture_start |=> !function_pin_one) else $error("busy without start");
  a_boot_quiet: assert property (
    !ready |-> !nv_we && !capture_start) else $error("activity before boot load end");
  a_ready_stays: assert property (
    ready |=> $stable(ready)) else $error("ready dropped without reset");
  a_save_slots: assert property (
    nv_we |-> nv_slot != 4'hb && nv_slot <= 4'hd) else $error("bad slot saved");

  cover property (capture_start);
  cover property (capture_done ##1 !function_pin_one);
  cover property (nv_we);
endmodule // vsp_reg_port_chk

bind vsp_reg_port vsp_reg_port_chk u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .cs_n(cs_n),
  .dout_oe_n(dout_oe_n),
  .function_pin_one(function_pin_one),
  .function_pin_one_oe_n(function_pin_one_oe_n),
  .capture_start(capture_start),
  .capture_done(capture_done),
  .nv_slot(nv_slot),
  .nv_we(nv_we),
  .ready(ready)
);
